/* File: rtl/osb_consts.svh */
// constants shared by both ends of the optical module sideband link
`ifndef OSB_CONSTS_SVH
`define OSB_CONSTS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define OSB_CLK_NS 4
`define OSB_QTR_NS 2500
`define OSB_QTR_CYC (`OSB_QTR_NS / `OSB_CLK_NS)

// ------------------------------------------------------------
// two-wire bus
// ------------------------------------------------------------
`define OSB_DEV_ADDR 7'h50
`define OSB_SYNC_RST 5'h1f

// ------------------------------------------------------------
// module-side registers reached over the two-wire bus
// ------------------------------------------------------------
`define OSB_D_STATUS 8'h00
`define OSB_D_FLAGS 8'h01
`define OSB_D_MASK 8'h02
`define OSB_D_CTRL 8'h03
`define OSB_B_LOS 0
`define OSB_B_NR 1
`define OSB_B_TXOFF 2
`define OSB_B_LOWPWR 3
`define OSB_B_SOFTOFF 0
`define OSB_MASK_RST 8'h03
`define OSB_CTRL_RST 8'h00
`define OSB_STAT_RST 8'h0c

// ------------------------------------------------------------
// host controller registers
// ------------------------------------------------------------
`define OSB_H_CTRL 3'h0
`define OSB_H_PINS 3'h1
`define OSB_H_CMD 3'h2
`define OSB_H_PTR 3'h3
`define OSB_H_WDATA 3'h4
`define OSB_H_RDATA 3'h5
`define OSB_H_ISTAT 3'h6
`define OSB_H_IMASK 3'h7
`define OSB_HC_TXOFF 0
`define OSB_HC_PDN 1
`define OSB_HC_SEL 2
`define OSB_HCTRL_RST 8'h03
`define OSB_CMD_GO 0
`define OSB_CMD_RD 1
`define OSB_CMD_PTR 2
`define OSB_P_ATT 0
`define OSB_P_NR 1
`define OSB_P_LOS 2
`define OSB_P_ABS 3
`define OSB_P_BUSY 4
`define OSB_I_DONE 0
`define OSB_I_NACK 1
`define OSB_I_ATT 2

`endif

/* File: rtl/osb_pkg.sv */
// types shared by both ends of the optical module sideband link
package osb_pkg;

  // two-wire slave byte phases, gray along addr, pointer, write data
  typedef enum logic [2:0] {
    OSB_S_IDLE = 3'b000,
    OSB_S_ADDR = 3'b001,
    OSB_S_PTR  = 3'b011,
    OSB_S_WDAT = 3'b010,
    OSB_S_RDAT = 3'b110
  } osb_slv_t;

  // two-wire master phases, gray along start, bits, stop
  typedef enum logic [1:0] {
    OSB_M_IDLE = 2'b00,
    OSB_M_STRT = 2'b01,
    OSB_M_BITS = 2'b11,
    OSB_M_STOP = 2'b10
  } osb_mst_t;

endpackage : osb_pkg

/* File: rtl/osb_link_if.sv */
// pins between host board and optical module, with pull-ups resolved
`timescale 1ns/1ps

interface osb_link_if;
  // host-driven levels: output and active-low enable
  logic tx_off_o;
  logic tx_off_oe_n;
  logic sel_n_o;
  logic sel_n_oe_n;
  logic pdn_o;
  logic pdn_oe_n;
  // two-wire bus, open drain on both ends
  logic scl_h_o;
  logic scl_h_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  // module open-collector outputs
  logic att_o;
  logic att_oe_n;
  logic nr_o;
  logic nr_oe_n;
  logic los_o;
  logic los_oe_n;
  logic abs_o;
  logic abs_oe_n;
  // resolved wire levels
  logic transmit_off_in;
  logic module_select_n;
  logic pdn_in;
  logic scl;
  logic sda;
  logic attention_out_n;
  logic not_ready_fault_out;
  logic rx_signal_lost_out;
  logic module_absent_out;

  // module pull-ups on transmit-off, select and power-down, host pull-ups elsewhere
  assign transmit_off_in = tx_off_oe_n ? 1'b1 : tx_off_o;
  assign pdn_in = pdn_oe_n ? 1'b1 : pdn_o;
  assign module_select_n = sel_n_oe_n ? 1'b1 : sel_n_o;
  assign scl = scl_h_oe_n | scl_h_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  assign attention_out_n = att_oe_n | att_o;
  assign not_ready_fault_out = nr_oe_n | nr_o;
  assign rx_signal_lost_out = los_oe_n | los_o;
  assign module_absent_out = abs_oe_n | abs_o;

  modport dev (
    input transmit_off_in, module_select_n, pdn_in, scl, sda,
    output sda_d_o, sda_d_oe_n, att_o, att_oe_n, nr_o, nr_oe_n,
    output los_o, los_oe_n, abs_o, abs_oe_n
  );

  modport host (
    input scl, sda, attention_out_n, not_ready_fault_out, rx_signal_lost_out, module_absent_out,
    output tx_off_o, tx_off_oe_n, sel_n_o, sel_n_oe_n, pdn_o, pdn_oe_n,
    output scl_h_o, scl_h_oe_n, sda_h_o, sda_h_oe_n
  );
endinterface : osb_link_if

/* File: rtl/osb_dev_end.sv */
// module end of the sideband link: pin control, status pins, two-wire slave
// Functional notes
// RULE1: transmit-off high turns transmitter off
// RULE2: undriven transmit-off reads high, transmitter off
// RULE3: answer two-wire address 1010000 only
// RULE4: answer the bus only while selected
// RULE5: attention pin low on flagged condition
// RULE6: not-ready pin released high on fault
// RULE7: not-ready equals tx lock loss OR rx
// RULE8: signal-lost pin high on low input power
// RULE9: presence pin tied low by module
// RULE10: power-down high limits power; fall resets
// RULE11: synchronise pins; reset edge on synced value
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "osb_consts.svh"

module osb_dev_end (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // pins toward the host
  osb_link_if.dev LINK,
  // module internals
  input wire logic TX_LOL,
  input wire logic RX_LOL,
  input wire logic RX_POWER_LOW,
  output logic TX_LASER_ON,
  output logic LOW_POWER,
  output logic MODULE_RESET
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [4:0] pin_raw;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] sync3_q;

  assign pin_raw = {LINK.transmit_off_in, LINK.module_select_n, LINK.pdn_in, LINK.scl, LINK.sda};

  // RULE11 two-flop synchronisers
  // reset high so a missing host reads as off, deselected, powered down
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      always_ff @(posedge REF_CLK or posedge RESET)
      begin
        if (RESET)
        begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
          sync3_q[gi] <= 1'b1;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // decoded pin events, all taken from the second stage onward
  // ------------------------------------------------------------
  wire s_txoff = sync2_q[4];
  wire s_sel = ~sync2_q[3];
  wire s_pdn = sync2_q[2];
  wire s_sda = sync2_q[0];
  wire scl_rise = sync2_q[1] & ~sync3_q[1];
  wire scl_fall = ~sync2_q[1] & sync3_q[1];
  wire scl_hi = sync2_q[1] & sync3_q[1];
  wire bus_start = scl_hi & sync3_q[0] & ~sync2_q[0];
  wire bus_stop = scl_hi & ~sync3_q[0] & sync2_q[0];
  // RULE10 falling edge of power-down requests full reset
  wire pdn_fall = sync3_q[2] & ~sync2_q[2];

  logic mod_rst_q;
  logic laser_q;
  logic att_q;
  logic nr_q;
  logic los_q;
  logic [7:0] flags_q;
  logic [7:0] mask_q;
  logic [7:0] ctrl_q;
  logic [7:0] prev_q;
  osb_pkg::osb_slv_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic rd_q;
  logic nack_q;
  logic sda_low_q;

  // ------------------------------------------------------------
  // status and register access decode
  // ------------------------------------------------------------
  wire [7:0] stat_now = {4'h0, s_pdn, s_txoff | ctrl_q[`OSB_B_SOFTOFF], nr_q, los_q};
  // RULE4 bus logic runs only while selected
  wire slv_run = s_sel & ~bus_stop & ~mod_rst_q & ~bus_start;
  wire byte_end = slv_run & scl_fall & (bit_q == 4'h7);
  wire wr_en = byte_end & (st_q == osb_pkg::OSB_S_WDAT);
  wire wr_flags = wr_en & (ptr_q == `OSB_D_FLAGS);
  wire wr_mask = wr_en & (ptr_q == `OSB_D_MASK);
  wire wr_ctrl = wr_en & (ptr_q == `OSB_D_CTRL);
  wire [7:0] rd_data = (ptr_q == `OSB_D_STATUS) ? stat_now :
                       (ptr_q == `OSB_D_FLAGS) ? flags_q :
                       (ptr_q == `OSB_D_MASK) ? mask_q :
                       (ptr_q == `OSB_D_CTRL) ? ctrl_q : 8'h00;
  wire [7:0] rise = stat_now & ~prev_q;
  wire [7:0] clr = wr_flags ? sh_q : 8'h00;

  // ------------------------------------------------------------
  // pin outputs and module control
  // ------------------------------------------------------------
  // registered so every pin changes cleanly on the clock
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      mod_rst_q <= 1'b0;
      laser_q <= 1'b0;
      att_q <= 1'b0;
      nr_q <= 1'b0;
      los_q <= 1'b0;
    end
    else
    begin
      mod_rst_q <= pdn_fall;
      // RULE1 laser on only while transmit-off low
      // RULE2 synchroniser reset and pull-up keep it off
      laser_q <= ~s_txoff & ~ctrl_q[`OSB_B_SOFTOFF] & ~s_pdn;
      // RULE5 attention from unmasked sticky flags
      att_q <= |(flags_q & mask_q);
      // RULE7 not-ready is the OR of both lock losses
      nr_q <= TX_LOL | RX_LOL;
      // RULE8 signal lost follows low input power
      los_q <= RX_POWER_LOW;
    end
  end

  assign TX_LASER_ON = laser_q;
  assign LOW_POWER = s_pdn;
  assign MODULE_RESET = mod_rst_q;

  // open collector: enable low pulls the wire low
  assign LINK.att_o = 1'b0;
  assign LINK.att_oe_n = ~att_q;
  // RULE6 released, so pulled high, while a fault stands
  assign LINK.nr_o = 1'b0;
  assign LINK.nr_oe_n = nr_q;
  assign LINK.los_o = 1'b0;
  assign LINK.los_oe_n = los_q;
  // RULE9 presence pin always grounded
  assign LINK.abs_o = 1'b0;
  assign LINK.abs_oe_n = 1'b0;
  assign LINK.sda_d_o = 1'b0;
  assign LINK.sda_d_oe_n = ~sda_low_q;

  // ------------------------------------------------------------
  // registers seen over the two-wire bus
  // ------------------------------------------------------------
  // a new rise beats a write-one-to-clear in the same cycle
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      flags_q <= 8'h00;
      mask_q <= `OSB_MASK_RST;
      ctrl_q <= `OSB_CTRL_RST;
      prev_q <= `OSB_STAT_RST;
    end
    else if (mod_rst_q)
    begin
      // RULE10 module reset restores register defaults
      flags_q <= 8'h00;
      mask_q <= `OSB_MASK_RST;
      ctrl_q <= `OSB_CTRL_RST;
      prev_q <= stat_now;
    end
    else
    begin
      prev_q <= stat_now;
      flags_q <= (flags_q & ~clr) | rise;
      if (wr_mask)
        mask_q <= sh_q;
      if (wr_ctrl)
        ctrl_q <= sh_q;
    end
  end

  // ------------------------------------------------------------
  // two-wire slave
  // ------------------------------------------------------------
  // samples on scl rise, changes sda after scl fall; the sync delay
  // is far below the quarter bit the host leaves for data setup
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      st_q <= osb_pkg::OSB_S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end
    else if (~s_sel | bus_stop | mod_rst_q)
    begin
      // RULE4 deselect drops the transfer and frees sda
      st_q <= osb_pkg::OSB_S_IDLE;
      sda_low_q <= 1'b0;
    end
    else if (bus_start)
    begin
      st_q <= osb_pkg::OSB_S_ADDR;
      bit_q <= 4'hf;
      sda_low_q <= 1'b0;
    end
    else if (st_q != osb_pkg::OSB_S_IDLE)
    begin
      if (scl_rise && bit_q < 4'h8 && st_q != osb_pkg::OSB_S_RDAT)
        sh_q <= {sh_q[6:0], s_sda};
      if (scl_rise && bit_q == 4'h8)
        nack_q <= s_sda;
      if (scl_fall)
      begin
        case (bit_q)
          4'h7:
          begin
            bit_q <= 4'h8;
            case (st_q)
              // RULE3 acknowledge own address only
              osb_pkg::OSB_S_ADDR:
              begin
                if (sh_q[7:1] == `OSB_DEV_ADDR)
                begin
                  sda_low_q <= 1'b1;
                  rd_q <= sh_q[0];
                end
                else
                  st_q <= osb_pkg::OSB_S_IDLE;
              end
              osb_pkg::OSB_S_PTR:
              begin
                ptr_q <= sh_q;
                sda_low_q <= 1'b1;
              end
              osb_pkg::OSB_S_WDAT:
              begin
                ptr_q <= ptr_q + 8'h01;
                sda_low_q <= 1'b1;
              end
              default: sda_low_q <= 1'b0;
            endcase
          end
          4'h8:
          begin
            bit_q <= 4'h0;
            sda_low_q <= 1'b0;
            case (st_q)
              osb_pkg::OSB_S_ADDR:
                st_q <= rd_q ? osb_pkg::OSB_S_RDAT : osb_pkg::OSB_S_PTR;
              osb_pkg::OSB_S_PTR: st_q <= osb_pkg::OSB_S_WDAT;
              osb_pkg::OSB_S_RDAT:
              begin
                if (nack_q)
                  st_q <= osb_pkg::OSB_S_IDLE;
              end
              default: st_q <= st_q;
            endcase
            // load the byte to send for a read or a read that continues
            if ((st_q == osb_pkg::OSB_S_ADDR && rd_q) || (st_q == osb_pkg::OSB_S_RDAT && !nack_q))
            begin
              sh_q <= rd_data;
              ptr_q <= ptr_q + 8'h01;
              sda_low_q <= ~rd_data[7];
            end
          end
          default:
          begin
            bit_q <= bit_q + 4'h1;
            if (st_q == osb_pkg::OSB_S_RDAT)
            begin
              sh_q <= {sh_q[6:0], 1'b1};
              sda_low_q <= ~sh_q[6];
            end
          end
        endcase
      end
    end
  end

endmodule : osb_dev_end

/* File: rtl/osb_host_end.sv */
// host end of the sideband link: pin control, status, two-wire master
`timescale 1ns/1ps
`include "osb_consts.svh"

module osb_host_end (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // pins toward the module
  osb_link_if.host LINK,
  // software register port
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // interrupt
  output logic IRQ
);

  logic [7:0] ctrl_q;
  logic [7:0] ptr_byte_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] istat_q;
  logic [7:0] imask_q;
  logic [7:0] rdout_q;
  logic att_prev_q;
  logic cmd_rd_q;
  logic cmd_ptr_q;
  osb_pkg::osb_mst_t mst_q;
  logic [9:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [8:0] sh_q;
  logic [7:0] rx_q;
  logic scl_q;
  logic sda_q;
  logic nack_q;
  logic done_q;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire busy = mst_q != osb_pkg::OSB_M_IDLE;
  wire tick = qcnt_q == 10'(`OSB_QTR_CYC - 1);
  // a command written while busy is dropped
  wire go = REG_WR & (REG_ADDR == `OSB_H_CMD) & REG_WDATA[`OSB_CMD_GO] & ~busy;
  wire att_now = ~LINK.attention_out_n;
  wire [7:0] pins = {3'h0, busy, LINK.module_absent_out, LINK.rx_signal_lost_out,
                     LINK.not_ready_fault_out, att_now};
  wire [7:0] ev = {5'h00, att_now & ~att_prev_q, done_q & nack_q, done_q};
  wire [7:0] iclr = (REG_WR && REG_ADDR == `OSB_H_ISTAT) ? REG_WDATA : 8'h00;
  wire [1:0] last_byte = (cmd_rd_q | cmd_ptr_q) ? 2'h1 : 2'h2;
  wire rd_byte = cmd_rd_q & (byte_q == 2'h1);
  wire [7:0] nxt_byte = (byte_q == 2'h0) ? (cmd_rd_q ? 8'hff : ptr_byte_q) : wdata_q;
  wire [7:0] rmux = (REG_ADDR == `OSB_H_CTRL) ? ctrl_q :
                    (REG_ADDR == `OSB_H_PINS) ? pins :
                    (REG_ADDR == `OSB_H_PTR) ? ptr_byte_q :
                    (REG_ADDR == `OSB_H_WDATA) ? wdata_q :
                    (REG_ADDR == `OSB_H_RDATA) ? rdata_q :
                    (REG_ADDR == `OSB_H_ISTAT) ? istat_q :
                    (REG_ADDR == `OSB_H_IMASK) ? imask_q : 8'h00;

  // RULE10 power-down level, low gives normal run, fall resets module
  assign LINK.pdn_o = ctrl_q[`OSB_HC_PDN];
  assign LINK.pdn_oe_n = 1'b0;
  assign LINK.tx_off_o = ctrl_q[`OSB_HC_TXOFF];
  assign LINK.tx_off_oe_n = 1'b0;
  // RULE4 select is active low on the wire
  assign LINK.sel_n_o = ~ctrl_q[`OSB_HC_SEL];
  assign LINK.sel_n_oe_n = 1'b0;
  assign LINK.scl_h_o = 1'b0;
  assign LINK.scl_h_oe_n = scl_q;
  assign LINK.sda_h_o = 1'b0;
  assign LINK.sda_h_oe_n = sda_q;
  assign REG_RDATA = rdout_q;
  // RULE5 attention raises an interrupt, cause read over the bus
  assign IRQ = |(istat_q & imask_q);

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // event sets win over a write-one-to-clear in the same cycle
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl_q <= `OSB_HCTRL_RST;
      ptr_byte_q <= 8'h00;
      wdata_q <= 8'h00;
      istat_q <= 8'h00;
      imask_q <= 8'h00;
      rdout_q <= 8'h00;
      att_prev_q <= 1'b0;
    end
    else
    begin
      att_prev_q <= att_now;
      istat_q <= (istat_q & ~iclr) | ev;
      rdout_q <= REG_RD ? rmux : 8'h00;
      if (REG_WR && REG_ADDR == `OSB_H_CTRL)
        ctrl_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == `OSB_H_PTR)
        ptr_byte_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == `OSB_H_WDATA)
        wdata_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == `OSB_H_IMASK)
        imask_q <= REG_WDATA;
    end
  end

  // ------------------------------------------------------------
  // two-wire master, four quarters per bit
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      mst_q <= osb_pkg::OSB_M_IDLE;
      qcnt_q <= 10'h000;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 9'h1ff;
      rx_q <= 8'h00;
      rdata_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      cmd_rd_q <= 1'b0;
      cmd_ptr_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      qcnt_q <= (!busy || tick) ? 10'h000 : qcnt_q + 10'h001;
      if (go)
      begin
        // RULE3 first byte carries the fixed module address
        mst_q <= osb_pkg::OSB_M_STRT;
        ph_q <= 2'h0;
        byte_q <= 2'h0;
        bit_q <= 4'h0;
        nack_q <= 1'b0;
        cmd_rd_q <= REG_WDATA[`OSB_CMD_RD];
        cmd_ptr_q <= REG_WDATA[`OSB_CMD_PTR];
        sh_q <= {`OSB_DEV_ADDR, REG_WDATA[`OSB_CMD_RD], 1'b1};
      end
      else if (busy && tick)
      begin
        ph_q <= ph_q + 2'h1;
        case (mst_q)
          osb_pkg::OSB_M_STRT:
          begin
            if (ph_q == 2'h0)
              sda_q <= 1'b0;
            else if (ph_q == 2'h1)
              scl_q <= 1'b0;
            else
            begin
              sda_q <= sh_q[8];
              ph_q <= 2'h0;
              mst_q <= osb_pkg::OSB_M_BITS;
            end
          end
          osb_pkg::OSB_M_BITS:
          begin
            if (ph_q == 2'h0)
              scl_q <= 1'b1;
            else if (ph_q == 2'h1)
            begin
              if (bit_q < 4'h8)
                rx_q <= {rx_q[6:0], LINK.sda};
              else if (!rd_byte)
                nack_q <= LINK.sda;
            end
            else if (ph_q == 2'h2)
              scl_q <= 1'b0;
            else if (bit_q == 4'h8)
            begin
              bit_q <= 4'h0;
              if (nack_q || byte_q == last_byte)
              begin
                sda_q <= 1'b0;
                mst_q <= osb_pkg::OSB_M_STOP;
              end
              else
              begin
                byte_q <= byte_q + 2'h1;
                sh_q <= {nxt_byte, 1'b1};
                sda_q <= nxt_byte[7];
              end
            end
            else
            begin
              bit_q <= bit_q + 4'h1;
              sh_q <= {sh_q[7:0], 1'b1};
              sda_q <= sh_q[7];
            end
          end
          osb_pkg::OSB_M_STOP:
          begin
            if (ph_q == 2'h0)
              scl_q <= 1'b1;
            else if (ph_q == 2'h1)
              sda_q <= 1'b1;
            else
            begin
              mst_q <= osb_pkg::OSB_M_IDLE;
              done_q <= 1'b1;
              if (cmd_rd_q && !nack_q)
                rdata_q <= rx_q;
            end
          end
          default: mst_q <= osb_pkg::OSB_M_IDLE;
        endcase
      end
    end
  end

endmodule : osb_host_end

/* File: bench/osb_link_chk.sv */
// assertions on the sideband pins and the module-side status
`timescale 1ns/1ps

module osb_link_chk (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // pin levels
  input wire logic transmit_off_in,
  input wire logic module_select_n,
  input wire logic pdn_in,
  input wire logic scl,
  input wire logic sda_d_oe_n,
  input wire logic not_ready_fault_out,
  input wire logic rx_signal_lost_out,
  input wire logic module_absent_out,
  // module internals
  input wire logic TX_LOL,
  input wire logic RX_LOL,
  input wire logic RX_POWER_LOW,
  input wire logic TX_LASER_ON,
  input wire logic LOW_POWER,
  input wire logic MODULE_RESET
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_abs_tied: assert property (module_absent_out == 1'b0)
    else $error("presence pin not low");
  a_nr_or_lol: assert property ($stable(TX_LOL | RX_LOL) [*4] |-> not_ready_fault_out == (TX_LOL | RX_LOL))
    else $error("not-ready pin differs from lock loss");
  a_los_follow: assert property ($stable(RX_POWER_LOW) [*4] |-> rx_signal_lost_out == RX_POWER_LOW)
    else $error("signal-lost pin differs from input power");
  a_laser_off: assert property (transmit_off_in [*5] |-> !TX_LASER_ON)
    else $error("laser on while transmit-off high");
  a_low_power: assert property (pdn_in [*4] |-> LOW_POWER)
    else $error("power-down high without low power");
  a_reset_edge: assert property ($fell(pdn_in) |-> ##[1:6] MODULE_RESET)
    else $error("no module reset after power-down fall");
  a_reset_pulse: assert property (MODULE_RESET |=> !MODULE_RESET)
    else $error("module reset longer than one cycle");
  // module data drive may move only while the clock line is low
  a_sda_scl_low: assert property ($changed(sda_d_oe_n) |-> !scl)
    else $error("module moved data while clock high");
  a_desel_quiet: assert property (module_select_n [*8] |-> sda_d_oe_n)
    else $error("deselected module drove data");
endmodule : osb_link_chk

/* File: bench/testbench.sv */
// self-checking bench joining the host end and the module end over the pins
`timescale 1ns/1ps
`include "osb_consts.svh"

module testbench;
  logic clk, rst, tx_lol, rx_lol, rx_pwr_low, reg_wr, reg_rd, irq, laser_on, low_power, mod_rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  int error_cnt = 0;
  int num_checks = 0;

  // ------------------------------------------------------------
  // both ends and the checker on the shared pins
  // ------------------------------------------------------------
  osb_link_if lnk ();
  osb_dev_end i_osb_dev_end (.REF_CLK(clk), .RESET(rst), .LINK(lnk), .TX_LOL(tx_lol), .RX_LOL(rx_lol),
    .RX_POWER_LOW(rx_pwr_low), .TX_LASER_ON(laser_on), .LOW_POWER(low_power), .MODULE_RESET(mod_rst));
  osb_host_end i_osb_host_end (.REF_CLK(clk), .RESET(rst), .LINK(lnk), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq));
  osb_link_chk i_osb_link_chk (.REF_CLK(clk), .RESET(rst), .transmit_off_in(lnk.transmit_off_in),
    .module_select_n(lnk.module_select_n), .pdn_in(lnk.pdn_in), .scl(lnk.scl), .sda_d_oe_n(lnk.sda_d_oe_n),
    .not_ready_fault_out(lnk.not_ready_fault_out), .rx_signal_lost_out(lnk.rx_signal_lost_out),
    .module_absent_out(lnk.module_absent_out), .TX_LOL(tx_lol), .RX_LOL(rx_lol), .RX_POWER_LOW(rx_pwr_low),
    .TX_LASER_ON(laser_on), .LOW_POWER(low_power), .MODULE_RESET(mod_rst));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic chkb(input string what, input logic seen, input logic exp);
    chk(what, {7'h00, seen}, {7'h00, exp});
  endtask : chkb
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // poll busy under a bound; a transfer is some 49k cycles a byte pair
  task automatic wait_idle();
    int n;
    n = 0;
    d = 8'h10;
    while (d[4] !== 1'b0 && n < 40000)
    begin
      rd(`OSB_H_PINS);
      n++;
    end
    chkb("busy", d[4], 1'b0);
  endtask : wait_idle
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask : settle

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_state();
    rd(`OSB_H_CTRL);
    chk("host ctrl", d, 8'h03);
    rd(`OSB_H_PINS);
    chk("pins", d, 8'h00);
    chkb("absent", lnk.module_absent_out, 1'b0);
    chkb("txoff wire", lnk.transmit_off_in, 1'b1);
    chkb("laser", laser_on, 1'b0);
    chkb("low power", low_power, 1'b1);
  endtask : t_reset_state
  // every lock-loss combination, then low input power
  task automatic t_faults();
    for (int i = 0; i < 4; i++)
    begin
      tx_lol <= i[0];
      rx_lol <= i[1];
      settle();
      chkb("nr wire", lnk.not_ready_fault_out, i != 0);
      rd(`OSB_H_PINS);
      chk("pins nr", d, (i != 0) ? 8'h03 : 8'h00);
    end
    tx_lol <= 1'b0;
    rx_lol <= 1'b0;
    rx_pwr_low <= 1'b1;
    settle();
    chkb("los wire", lnk.rx_signal_lost_out, 1'b1);
    chkb("att wire", lnk.attention_out_n, 1'b0);
    rx_pwr_low <= 1'b0;
    settle();
    chkb("los clear", lnk.rx_signal_lost_out, 1'b0);
  endtask : t_faults
  task automatic t_power();
    int n;
    wr(`OSB_H_CTRL, 8'h00);
    n = 0;
    while (mod_rst !== 1'b1 && n < 20)
    begin
      @(posedge clk) #1;
      n++;
    end
    chkb("module reset", mod_rst, 1'b1);
    settle();
    chkb("low power off", low_power, 1'b0);
    chkb("laser on", laser_on, 1'b1);
    chkb("att released", lnk.attention_out_n, 1'b1);
    wr(`OSB_H_CTRL, 8'h01);
    settle();
    chkb("laser off", laser_on, 1'b0);
    wr(`OSB_H_CTRL, 8'h00);
    wr(`OSB_H_ISTAT, 8'h07);
  endtask : t_power
  // attention edge raised, masked, unmasked and cleared
  task automatic t_irq();
    wr(`OSB_H_IMASK, 8'h00);
    rx_pwr_low <= 1'b1;
    settle();
    chkb("att wire", lnk.attention_out_n, 1'b0);
    chkb("irq masked", irq, 1'b0);
    rd(`OSB_H_ISTAT);
    chk("istat att", d, 8'h04);
    wr(`OSB_H_IMASK, 8'h04);
    chkb("irq on", irq, 1'b1);
    wr(`OSB_H_ISTAT, 8'h04);
    chkb("irq cleared", irq, 1'b0);
    wr(`OSB_H_IMASK, 8'h03);
  endtask : t_irq
  task automatic t_desel();
    wr(`OSB_H_CMD, 8'h03);
    wait_idle();
    rd(`OSB_H_ISTAT);
    chkb("nack deselected", d[1], 1'b1);
    chkb("irq nack", irq, 1'b1);
    wr(`OSB_H_ISTAT, 8'h07);
  endtask : t_desel
  // status byte read at pointer zero: only signal lost is set
  task automatic t_read();
    wr(`OSB_H_CTRL, 8'h04);
    wr(`OSB_H_CMD, 8'h03);
    wait_idle();
    rd(`OSB_H_ISTAT);
    chk("istat done", d, 8'h01);
    rd(`OSB_H_RDATA);
    chk("status byte", d, 8'h01);
  endtask : t_read

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // two transfers need about 75k cycles; allow 100k
  initial
  begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    rst = 1'b1;
    {tx_lol, rx_lol, rx_pwr_low, reg_wr, reg_rd} = 5'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset_state();
    t_faults();
    t_power();
    t_irq();
    t_desel();
    t_read();
    wrap_up();
  end
endmodule : testbench
